// *** ncs_pkg.sv ***
// shared constants and types for the nickel charge sequencer
package ncs_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned CLK_PERIOD_NS = 4;
  // one second period, in ms as printed
  localparam int unsigned PERIOD_MS = 1000;
  localparam int unsigned SEC_CYCLES = (PERIOD_MS * (CLK_HZ / 1000));
  localparam int unsigned SEC_W = 28;
  // max charge duration in seconds, default
  localparam int unsigned MAX_DURATION_S = 3600;
  localparam int unsigned DUR_W = 20;
  localparam int unsigned HOLDOFF_DIV_SHIFT = 5;
  // top-off duty: 1/16 of the second
  localparam int unsigned TOPOFF_DIV_SHIFT = 4;
  localparam int unsigned PULSE_W = 28;
  typedef enum logic [2:0] {
    NCS_QUALIFY = 3'h0,
    NCS_CONDITION = 3'h1,
    NCS_FAST = 3'h2,
    NCS_TOPOFF = 3'h3,
    NCS_MAINT = 3'h4,
    NCS_SUSPEND = 3'h5,
    NCS_DONE = 3'h6
  } ncs_state_type;
endpackage

// *** ncs_tick_if.sv ***
// timebase signals shared between the sequencer and its timebase
`timescale 1ns/100ps
`default_nettype none
interface ncs_tick_if #(parameter int SEC_W = 28);
  logic sec_tick;
  logic half_phase;
  logic [SEC_W-1:0] phase;
  modport src (output sec_tick, output half_phase, output phase);
  modport dst (input sec_tick, input half_phase, input phase);
endinterface
`default_nettype wire

// *** ncs_timebase.sv ***
// one second timebase with phase count
`timescale 1ns/100ps
`default_nettype none
module ncs_timebase #(
  parameter int unsigned SEC_CYCLES = ncs_pkg::SEC_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic restart,
  ncs_tick_if.src tb
);
  logic [ncs_pkg::SEC_W-1:0] cnt_reg;
  logic [ncs_pkg::SEC_W-1:0] cnt_next;
  localparam logic [ncs_pkg::SEC_W-1:0] LAST = ncs_pkg::SEC_W'(SEC_CYCLES - 1);
  localparam logic [ncs_pkg::SEC_W-1:0] HALF = ncs_pkg::SEC_W'(SEC_CYCLES / 2);
  always_comb begin
    if (restart || cnt_reg == LAST) begin
      cnt_next = '0;
    end else begin
      cnt_next = cnt_reg + ncs_pkg::SEC_W'(1);
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  assign tb.sec_tick = (cnt_reg == LAST) && !restart;
  assign tb.half_phase = (cnt_reg < HALF);
  assign tb.phase = cnt_reg;
endmodule
`default_nettype wire

// *** ncs_sequencer.sv ***
// charge state sequencer for a nickel battery charger
// Notes on behaviour
// - power-up, pack swap or wake restart cycle
// - qualification checks voltage and temperature first
// - low cell voltage leads to conditioning
// - conditioning pulses charge switch once per second
// - trickle pulse width comes from configuration input
// - lamp flashes 1 Hz while qualifying or conditioning
// - exit conditioning needs voltage and temperature good
// - conditioning never times out
// - charge timer stopped during conditioning
// - fast charge checks time, temperature, voltage
// - lamp held on during fast charge
// - after fast charge, top-off if selected else maintenance
// - maintenance continues while below max cell voltage
// - charge switch high conducts, low blocks
// - fast charge ends on peak or timeout
// - peak detect ignored for duration over 32
// - cold during fast: pause timer, condition, resume
// - cutoff temperature in fast charge or top-off: suspend, lamp off
// - top-off pulse one sixteenth each second
`timescale 1ns/100ps
`default_nettype none
module ncs_sequencer #(
  parameter int unsigned SEC_CYCLES = ncs_pkg::SEC_CYCLES,
  parameter int unsigned MAX_DURATION_S = ncs_pkg::MAX_DURATION_S
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic power_applied,
  input wire logic pack_replaced,
  input wire logic sleep_exit,
  input wire logic cell_below_low,
  input wire logic temp_below_cold,
  input wire logic temp_above_hot,
  input wire logic temp_at_cutoff,
  input wire logic cell_at_max,
  input wire logic peak_drop_detect,
  input wire logic topoff_select,
  input wire logic [ncs_pkg::PULSE_W-1:0] trickle_width,
  output logic charge_switch_output,
  output logic status_lamp_out,
  output logic status_lamp_oe_b,
  output logic [2:0] charge_state
);
  localparam logic [ncs_pkg::DUR_W-1:0] DUR_MAX = ncs_pkg::DUR_W'(MAX_DURATION_S);
  localparam logic [ncs_pkg::DUR_W-1:0] HOLDOFF = ncs_pkg::DUR_W'(MAX_DURATION_S >> ncs_pkg::HOLDOFF_DIV_SHIFT);
  localparam logic [ncs_pkg::SEC_W-1:0] TOPOFF_W =
    ncs_pkg::SEC_W'(SEC_CYCLES >> ncs_pkg::TOPOFF_DIV_SHIFT);

  ncs_tick_if #(.SEC_W(ncs_pkg::SEC_W)) tb ();

  logic start;
  assign start = power_applied | pack_replaced | sleep_exit;

  ncs_timebase #(.SEC_CYCLES(SEC_CYCLES)) u_tb (
    .clk(clk),
    .rst_b(rst_b),
    .restart(start),
    .tb(tb.src)
  );

  ncs_pkg::ncs_state_type state_reg;
  ncs_pkg::ncs_state_type state_next;
  logic [ncs_pkg::DUR_W-1:0] elapsed_reg;
  logic [ncs_pkg::DUR_W-1:0] elapsed_next;
  logic paused_fast_reg;
  logic paused_fast_next;
  logic sw_reg;
  logic sw_next;
  logic lamp_on_reg;
  logic lamp_on_next;

  logic temp_ok;
  logic timed_out;
  logic peak_ok;
  assign temp_ok = !temp_below_cold && !temp_above_hot;
  assign timed_out = (elapsed_reg >= DUR_MAX);
  assign peak_ok = peak_drop_detect && (elapsed_reg >= HOLDOFF);

  always_comb begin
    state_next = state_reg;
    elapsed_next = elapsed_reg;
    paused_fast_next = paused_fast_reg;
    if (start) begin
      state_next = ncs_pkg::NCS_QUALIFY;
      elapsed_next = '0;
      paused_fast_next = 1'b0;
    end else begin
      unique case (state_reg)
        ncs_pkg::NCS_QUALIFY: begin
          if (cell_below_low || !temp_ok) begin
            state_next = ncs_pkg::NCS_CONDITION;
          end else begin
            state_next = ncs_pkg::NCS_FAST;
          end
        end
        ncs_pkg::NCS_CONDITION: begin
          // no exit other than good conditions; timer frozen
          if (!cell_below_low && temp_ok) begin
            state_next = ncs_pkg::NCS_FAST;
            if (!paused_fast_reg) begin
              elapsed_next = '0;
            end
            paused_fast_next = 1'b0;
          end
        end
        ncs_pkg::NCS_FAST: begin
          if (tb.sec_tick) begin
            elapsed_next = elapsed_reg + ncs_pkg::DUR_W'(1);
          end
          if (temp_at_cutoff) begin
            state_next = ncs_pkg::NCS_SUSPEND;
          end else if (temp_below_cold) begin
            state_next = ncs_pkg::NCS_CONDITION;
            // a second completed in fast charge still counts
            paused_fast_next = 1'b1;
          end else if (cell_at_max) begin
            state_next = ncs_pkg::NCS_DONE;
          end else if (peak_ok || timed_out) begin
            elapsed_next = '0;
            state_next = topoff_select ? ncs_pkg::NCS_TOPOFF : ncs_pkg::NCS_MAINT;
          end
        end
        ncs_pkg::NCS_TOPOFF: begin
          if (tb.sec_tick) begin
            elapsed_next = elapsed_reg + ncs_pkg::DUR_W'(1);
          end
          if (cell_at_max) begin
            state_next = ncs_pkg::NCS_DONE;
          end else if (temp_at_cutoff) begin
            state_next = ncs_pkg::NCS_SUSPEND;
          end else if (timed_out) begin
            state_next = ncs_pkg::NCS_MAINT;
          end
        end
        ncs_pkg::NCS_MAINT: begin
          if (cell_at_max) begin
            state_next = ncs_pkg::NCS_DONE;
          end
        end
        ncs_pkg::NCS_SUSPEND: begin
          // cutoff recovery only into maintenance
          if (!temp_above_hot && !temp_at_cutoff) begin
            state_next = ncs_pkg::NCS_MAINT;
          end
        end
        ncs_pkg::NCS_DONE: begin
          state_next = ncs_pkg::NCS_DONE;
        end
        default: begin
          state_next = ncs_pkg::NCS_QUALIFY;
        end
      endcase
    end
  end

  // output decode, registered
  always_comb begin
    sw_next = 1'b0;
    lamp_on_next = 1'b0;
    unique case (state_next)
      ncs_pkg::NCS_QUALIFY: begin
        lamp_on_next = tb.half_phase;
      end
      ncs_pkg::NCS_CONDITION: begin
        lamp_on_next = tb.half_phase;
        sw_next = (tb.phase < trickle_width);
      end
      ncs_pkg::NCS_FAST: begin
        lamp_on_next = 1'b1;
        sw_next = 1'b1;
      end
      ncs_pkg::NCS_TOPOFF: begin
        sw_next = !temp_above_hot && (tb.phase < TOPOFF_W);
      end
      ncs_pkg::NCS_MAINT: begin
        sw_next = !temp_above_hot && (tb.phase < trickle_width);
      end
      ncs_pkg::NCS_SUSPEND: begin
        lamp_on_next = 1'b0;
      end
      ncs_pkg::NCS_DONE: begin
        sw_next = 1'b0;
      end
      default: begin
        sw_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ncs_pkg::NCS_QUALIFY;
      elapsed_reg <= '0;
      paused_fast_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      elapsed_reg <= elapsed_next;
      paused_fast_reg <= paused_fast_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_reg <= 1'b0;
      lamp_on_reg <= 1'b0;
    end else begin
      sw_reg <= sw_next;
      lamp_on_reg <= lamp_on_next;
    end
  end

  assign charge_switch_output = sw_reg;
  assign status_lamp_out = 1'b0;
  assign status_lamp_oe_b = !lamp_on_reg;
  assign charge_state = state_reg;
endmodule
`default_nettype wire

// *** ncs_checker.sv ***
// port assertions for the charge sequencer
`timescale 1ns/100ps
`default_nettype none
module ncs_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic power_applied,
  input wire logic pack_replaced,
  input wire logic sleep_exit,
  input wire logic cell_below_low,
  input wire logic temp_below_cold,
  input wire logic temp_above_hot,
  input wire logic temp_at_cutoff,
  input wire logic charge_switch_output,
  input wire logic status_lamp_out,
  input wire logic status_lamp_oe_b,
  input wire logic [2:0] charge_state
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  wire logic rs = power_applied | pack_replaced | sleep_exit;
  a_restart_qualify: assert property (rs |=> charge_state == 3'h0)
    else $error("no qualify after restart");
  a_low_to_cond: assert property (charge_state == 3'h0 && cell_below_low && !rs |=> charge_state == 3'h1)
    else $error("low cell not conditioned");
  a_cond_stays: assert property (charge_state == 3'h1 && (cell_below_low || temp_below_cold || temp_above_hot) && !rs
    |=> charge_state == 3'h1)
    else $error("left conditioning early");
  a_cond_exit: assert property (charge_state == 3'h1 && !cell_below_low && !temp_below_cold && !temp_above_hot && !rs
    |=> charge_state == 3'h2)
    else $error("no fast after good pack");
  a_fast_lit: assert property (charge_state == 3'h2 |-> !status_lamp_oe_b && !status_lamp_out)
    else $error("lamp dark in fast charge");
  a_cold_fallback: assert property (charge_state == 3'h2 && temp_below_cold && !temp_at_cutoff && !rs
    |=> charge_state == 3'h1)
    else $error("cold fast not conditioned");
  a_cutoff_suspend: assert property (charge_state == 3'h2 && temp_at_cutoff && !rs |=> charge_state == 3'h5)
    else $error("cutoff not suspended");
  a_suspend_dark: assert property (charge_state == 3'h5 |-> status_lamp_oe_b && !charge_switch_output)
    else $error("suspend lamp or switch on");
endmodule
bind ncs_sequencer ncs_checker ncs_checker_inst (.clk(clk), .rst_b(rst_b), .power_applied(power_applied),
  .pack_replaced(pack_replaced), .sleep_exit(sleep_exit), .cell_below_low(cell_below_low),
  .temp_below_cold(temp_below_cold), .temp_above_hot(temp_above_hot), .temp_at_cutoff(temp_at_cutoff),
  .charge_switch_output(charge_switch_output), .status_lamp_out(status_lamp_out),
  .status_lamp_oe_b(status_lamp_oe_b), .charge_state(charge_state));
`default_nettype wire

// *** ncs_pack_model.sv ***
// depleted pack that recovers once charge goes in
`timescale 1ns/100ps
`default_nettype none
module ncs_pack_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic charge_switch_output,
  input wire logic depleted,
  output logic cell_below_low
);
  logic [3:0] fill_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fill_reg <= 4'h0;
    end else if (!depleted) begin
      fill_reg <= 4'h0;
    end else if (charge_switch_output && fill_reg != 4'h8) begin
      fill_reg <= fill_reg + 4'h1;
    end
  end
  assign cell_below_low = depleted && fill_reg != 4'h8;
endmodule
`default_nettype wire

// *** tb.sv ***
// self-checking testbench for the charge sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int SC = 64;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic pwr = 1'b0, swp = 1'b0, slp = 1'b0, cold = 1'b0, hot = 1'b0, cut = 1'b0;
  logic mx = 1'b0, pk = 1'b0, tsel = 1'b0, dep = 1'b1;
  logic [27:0] tw = 28'h5;
  logic low, sw, lo, oe_b;
  logic [2:0] st;
  int n_mismatch = 0;
  int n_tests = 0;
  int n, c, l;
  always #2 clk = ~clk;
  ncs_pack_model ncs_pack_model_inst (.clk(clk), .rst_b(rst_b), .charge_switch_output(sw), .depleted(dep),
    .cell_below_low(low));
  ncs_sequencer #(.SEC_CYCLES(SC), .MAX_DURATION_S(64)) ncs_sequencer_inst (.clk(clk), .rst_b(rst_b),
    .power_applied(pwr), .pack_replaced(swp), .sleep_exit(slp), .cell_below_low(low), .temp_below_cold(cold),
    .temp_above_hot(hot), .temp_at_cutoff(cut), .cell_at_max(mx), .peak_drop_detect(pk), .topoff_select(tsel),
    .trickle_width(tw), .charge_switch_output(sw), .status_lamp_out(lo), .status_lamp_oe_b(oe_b),
    .charge_state(st));
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic wait_st(logic [2:0] s, int lim);
    // first look off the edge, never at the launching edge
    @(negedge clk);
    for (n = 0; n < lim && st !== s; n++) @(negedge clk);
    n_tests++;
    if (st !== s) begin
      n_mismatch++;
      $display("[FAIL] state expected %0h seen %0h", s, st);
      tally_and_finish();
    end
  endtask
  task automatic count(int k);
    c = 0;
    l = 0;
    repeat (k) begin
      @(negedge clk);
      c += (sw === 1'b1);
      l += (oe_b === 1'b0);
    end
  endtask
  task automatic restart(int which);
    @(posedge clk);
    pwr <= (which == 0);
    swp <= (which == 1);
    slp <= (which == 2);
    @(posedge clk);
    pwr <= 1'b0;
    swp <= 1'b0;
    slp <= 1'b0;
  endtask
  task automatic t_condition();
    hot <= 1'b1;
    restart(0);
    wait_st(3'h1, 10);
    count(SC);
    chk("trickle cycles", 5, c);
    chk("flash lit cycles", SC / 2, l);
    count(3 * SC);
    chk("cond state", 1, st);
    @(posedge clk) hot <= 1'b0;
    wait_st(3'h2, 4);
    count(8);
    chk("fast lamp", 8, l);
    chk("fast switch", 8, c);
  endtask
  task automatic t_holdoff_topoff();
    @(posedge clk) pk <= 1'b1;
    tsel <= 1'b1;
    wait_st(3'h3, 3 * SC);
    chk("holdoff long", 1, n > SC && n <= 2 * SC + 2);
    @(posedge clk) pk <= 1'b0;
    count(SC);
    chk("topoff cycles", SC / 16, c);
    @(posedge clk) mx <= 1'b1;
    wait_st(3'h6, 4);
    @(posedge clk) mx <= 1'b0;
  endtask
  task automatic t_timer_pause();
    tsel <= 1'b0;
    dep <= 1'b0;
    restart(2);
    wait_st(3'h2, 4);
    count(30 * SC);
    @(posedge clk) cold <= 1'b1;
    wait_st(3'h1, 4);
    count(20 * SC);
    @(posedge clk) cold <= 1'b0;
    wait_st(3'h2, 4);
    wait_st(3'h4, 37 * SC);
    chk("resumed timer", 1, n > 32 * SC);
    count(SC);
    chk("maint trickle", 5, c);
  endtask
  task automatic t_cutoff();
    restart(1);
    wait_st(3'h2, 4);
    @(posedge clk) cut <= 1'b1;
    wait_st(3'h5, 4);
    count(8);
    chk("suspend lit", 0, l + c);
    @(posedge clk) cut <= 1'b0;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_condition();
    t_holdoff_topoff();
    t_timer_pause();
    t_cutoff();
    tally_and_finish();
  end
endmodule
`default_nettype wire
